// ==== src/csp_channel_setup_parser.sv ====
// Channel setup command parser: receives the setup sequence over the serial port,
// checks its shape and applies the half-channel settings it carries.
// Assumes i_clk at 100 MHz, a serial clock well slower, and identity straps held static.
`timescale 1ns/100ps
`include "csp_regs.svh"

module csp_channel_setup_parser (
  // System clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_arst_n,
  // Serial setup port
  input  wire logic                       i_serial_clk,
  input  wire logic                       i_serial_data_line,
  input  wire logic                       i_port_select_n,
  // Identity straps
  input  wire logic                       i_identity_strap_high,
  input  wire logic                       i_identity_strap_low,
  // Applied half-channel settings
  output csp_pkg::csp_hcfg_s [7:0]        o_cfg,
  output logic               [7:0]        o_in_on_y,
  output logic               [7:0]        o_out_on_y,
  output logic               [7:0]        o_conf_alloc,
  output logic               [7:0]        o_codec_alloc,
  output logic               [7:0]        o_echo_alloc,
  output logic               [7:0]        o_decode,
  output logic               [7:0][2:0]   o_sample_bits,
  // Sequence outcome pulses
  output logic                            o_cfg_applied,
  output logic                            o_seq_rejected
);

  // Whole state of the i_clk domain
  typedef struct packed {
    csp_pkg::csp_state_e      state;
    logic [2:0]               byte_idx;
    logic [3:0]               entry_cnt;
    logic                     tog_seen;
    logic                     sel_seen_n;
    csp_pkg::csp_hcfg_s [7:0] stage;
    csp_pkg::csp_hcfg_s [7:0] active;
    logic                     applied;
    logic                     rejected;
  } csp_core_s;

  csp_core_s               core_reg;
  csp_core_s               core_next;
  csp_pkg::csp_link_byte_s link_byte;
  logic [3:0]              sync_out;
  logic                    tog_sync;
  logic                    sel_n_sync;
  logic [1:0]              strap_id;
  logic                    byte_evt;
  logic                    sel_rise;
  logic [7:0]              rx;

  // Reset value of one half-channel: 0-3 decode on Y, 4-7 encode on X
  function automatic csp_pkg::csp_hcfg_s default_cfg(input logic [2:0] idx);
    csp_pkg::csp_hcfg_s c;
    logic [7:0]         slot;
    slot = {6'h00, idx[1:0]};
    c.conf_alloc             = `CSP_RST_CONF;
    c.codec_alloc_flag       = `CSP_RST_CODEC;
    c.rate                   = `CSP_RST_RATE;
    c.echo_reference_channel = {1'b0, ~idx[2], idx[1:0]};
    if (!idx[2]) begin
      c.route         = csp_pkg::CSP_ROUTE_YY;
      c.decode        = 1'b1;
      c.echo_delay_ms = 8'h00;
      c.in_begin      = 8'(slot * `CSP_ADPCM_BITS);
      c.in_end        = 8'(slot * `CSP_ADPCM_BITS + `CSP_ADPCM_BITS - 8'h01);
      c.out_begin     = 8'(slot * `CSP_PCM_BITS);
      c.out_end       = 8'(slot * `CSP_PCM_BITS + `CSP_PCM_BITS - 8'h01);
    end else begin
      c.route         = csp_pkg::CSP_ROUTE_XX;
      c.decode        = 1'b0;
      c.echo_delay_ms = `CSP_RST_DELAY_EC;
      c.in_begin      = 8'(slot * `CSP_PCM_BITS);
      c.in_end        = 8'(slot * `CSP_PCM_BITS + `CSP_PCM_BITS - 8'h01);
      c.out_begin     = 8'(slot * `CSP_ADPCM_BITS);
      c.out_end       = 8'(slot * `CSP_ADPCM_BITS + `CSP_ADPCM_BITS - 8'h01);
    end
    return c;
  endfunction : default_cfg

  // Writes entry byte number idx into one half-channel record
  function automatic csp_pkg::csp_hcfg_s put_byte(input csp_pkg::csp_hcfg_s c_in,
                                                  input logic [2:0]         idx,
                                                  input logic [7:0]         b);
    csp_pkg::csp_hcfg_s c;
    c = c_in;
    unique case (idx)
      3'h0: begin
        c.route                  = csp_pkg::csp_route_e'(b[`CSP_B0_ROUTE_MSB:`CSP_B0_ROUTE_LSB]);
        c.conf_alloc             = b[`CSP_B0_CONF_BIT];
        c.codec_alloc_flag       = b[`CSP_B0_CODEC_BIT];
        c.echo_reference_channel = b[`CSP_B0_REF_MSB:`CSP_B0_REF_LSB];
      end
      3'h1: begin
        c.decode = b[`CSP_B1_DEC_BIT];
        c.rate   = b[`CSP_B1_RATE_MSB:`CSP_B1_RATE_LSB];
      end
      3'h2: c.echo_delay_ms = b;
      3'h3: c.in_begin      = b;
      3'h4: c.in_end        = b;
      3'h5: c.out_begin     = b;
      3'h6: c.out_end       = b;
      default: c = c_in;                                    // Index 7 never occurs
    endcase
    return c;
  endfunction : put_byte

  // Bits per codec sample for a bitrate code: 16k to 40k at 8 kHz
  function automatic logic [2:0] rate_bits(input logic [1:0] rate);
    return 3'(rate) + 3'h2;
  endfunction : rate_bits

  // Link-side byte assembly runs on the serial clock
  csp_link_rx u_link_rx (
    .i_serial_clk       (i_serial_clk),
    .i_arst_n           (i_arst_n),
    .i_port_select_n    (i_port_select_n),
    .i_serial_data_line (i_serial_data_line),
    .o_byte             (link_byte)
  );

  // Toggle, select and straps come from other domains or pins
  csp_sync2 #(
    .WIDTH (4),
    .RST   (32'h4)
  ) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({link_byte.toggle, i_port_select_n,
                i_identity_strap_high, i_identity_strap_low}),
    .o_sync   (sync_out)
  );

  assign tog_sync   = sync_out[3];
  assign sel_n_sync = sync_out[2];
  assign strap_id   = sync_out[1:0];

  // Byte data is stable for many i_clk cycles once its toggle has crossed
  assign byte_evt = tog_sync != core_reg.tog_seen;
  assign sel_rise = sel_n_sync & ~core_reg.sel_seen_n;
  assign rx       = link_byte.data;

  // Parser: header, entries, footer, then wait for deselect
  always_comb begin
    core_next          = core_reg;
    core_next.tog_seen = tog_sync;
    core_next.sel_seen_n = sel_n_sync;
    core_next.applied  = 1'b0;
    core_next.rejected = 1'b0;
    if (byte_evt) begin
      unique case (core_reg.state)
        csp_pkg::CSP_ST_HEADER: begin
          // Wrong identity leaves the sequence to another chip
          if (rx[`CSP_HDR_ZERO_MSB:`CSP_HDR_ZERO_LSB] == 6'h00 &&
              rx[`CSP_HDR_ID_MSB:`CSP_HDR_ID_LSB] == strap_id) begin
            core_next.state     = csp_pkg::CSP_ST_BOUNDARY;
            core_next.entry_cnt = 4'h0;
          end else begin
            core_next.state     = csp_pkg::CSP_ST_SKIP;
          end
        end
        csp_pkg::CSP_ST_BOUNDARY: begin
          if (rx == `CSP_FOOTER) begin
            // Only now do staged entries reach the outputs
            for (int i = 0; i < 8; i++) begin
              if (4'(i) < core_reg.entry_cnt) begin
                core_next.active[i] = core_reg.stage[i];
              end
            end
            core_next.applied = 1'b1;
            core_next.state   = csp_pkg::CSP_ST_SKIP;
          end else if (core_reg.entry_cnt == `CSP_MAX_ENTRIES) begin
            core_next.rejected = 1'b1;
            core_next.state    = csp_pkg::CSP_ST_SKIP;
          end else begin
            core_next.stage[core_reg.entry_cnt[2:0]] =
              put_byte(core_reg.stage[core_reg.entry_cnt[2:0]], 3'h0, rx);
            core_next.byte_idx = 3'h1;
            core_next.state    = csp_pkg::CSP_ST_ENTRY;
          end
        end
        csp_pkg::CSP_ST_ENTRY: begin
          // Second byte must carry its fixed bits or the sequence is bad
          if (core_reg.byte_idx == 3'h1 &&
              (rx[`CSP_B1_ZERO_BIT] != 1'b0 ||
               rx[`CSP_B1_PAT_MSB:`CSP_B1_PAT_LSB] != `CSP_B1_PATTERN)) begin
            core_next.rejected = 1'b1;
            core_next.state    = csp_pkg::CSP_ST_SKIP;
          end else begin
            core_next.stage[core_reg.entry_cnt[2:0]] =
              put_byte(core_reg.stage[core_reg.entry_cnt[2:0]], core_reg.byte_idx, rx);
            if (core_reg.byte_idx == `CSP_ENTRY_LAST) begin
              core_next.entry_cnt = core_reg.entry_cnt + 4'h1;
              core_next.state     = csp_pkg::CSP_ST_BOUNDARY;
            end else begin
              core_next.byte_idx  = core_reg.byte_idx + 3'h1;
            end
          end
        end
        csp_pkg::CSP_ST_SKIP: begin
          core_next.state = csp_pkg::CSP_ST_SKIP;   // Extra bytes after footer ignored
        end
      endcase
    end
    // Deselect ends every sequence; an unfinished one is dropped
    if (sel_rise) begin
      if (core_next.state == csp_pkg::CSP_ST_ENTRY ||
          core_next.state == csp_pkg::CSP_ST_BOUNDARY) begin
        core_next.rejected = 1'b1;
      end
      core_next.state    = csp_pkg::CSP_ST_HEADER;
      core_next.byte_idx = 3'h0;
    end
  end

  // Defaults of all eight half-channels load at reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      core_reg            <= '0;
      core_reg.state      <= csp_pkg::CSP_ST_HEADER;
      core_reg.sel_seen_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        core_reg.active[i] <= default_cfg(3'(i));
        core_reg.stage[i]  <= default_cfg(3'(i));
      end
    end else begin
      core_reg <= core_next;
    end
  end

  // Settings out, straight from flops
  assign o_cfg          = core_reg.active;
  assign o_cfg_applied  = core_reg.applied;
  assign o_seq_rejected = core_reg.rejected;

  // Decoded views of each half-channel setting
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      o_in_on_y[i]     = core_reg.active[i].route[1];
      o_out_on_y[i]    = core_reg.active[i].route[0];
      o_conf_alloc[i]  = core_reg.active[i].conf_alloc;
      o_codec_alloc[i] = core_reg.active[i].codec_alloc_flag;
      o_echo_alloc[i]  = core_reg.active[i].echo_delay_ms != 8'h00;
      o_decode[i]      = core_reg.active[i].decode;
      o_sample_bits[i] = rate_bits(core_reg.active[i].rate);
    end
  end

endmodule : csp_channel_setup_parser

// ==== src/csp_link_rx.sv ====
// Serial-clock side of the setup port: shifts bits in LSB first, flags each byte.
// Assumes the serial clock only toggles while the port is selected.
`timescale 1ns/100ps
`include "csp_regs.svh"

module csp_link_rx (
  // Link clock and resets
  input  wire logic              i_serial_clk,
  input  wire logic              i_arst_n,
  // Link pins
  input  wire logic              i_port_select_n,
  input  wire logic              i_serial_data_line,
  // Completed byte with its toggle
  output csp_pkg::csp_link_byte_s o_byte
);

  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] shift;
  } csp_shift_s;

  csp_shift_s               shift_reg;
  csp_shift_s               shift_next;
  csp_pkg::csp_link_byte_s  byte_reg;
  csp_pkg::csp_link_byte_s  byte_next;
  logic                     frame_rst_n;
  logic [7:0]               full_byte;

  // Deselect clears a half-shifted byte; the clock may never tick again
  assign frame_rst_n = i_arst_n & ~i_port_select_n;
  assign full_byte   = {i_serial_data_line, shift_reg.shift[7:1]};

  // Rising edge sampling, least significant bit first
  always_comb begin
    shift_next         = shift_reg;
    byte_next          = byte_reg;
    shift_next.shift   = full_byte;
    shift_next.bit_cnt = shift_reg.bit_cnt + 3'h1;
    if (shift_reg.bit_cnt == `CSP_BYTE_LAST) begin
      byte_next.data   = full_byte;
      byte_next.toggle = ~byte_reg.toggle;
    end
  end

  always_ff @(posedge i_serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Toggle survives deselect so the far side never sees a false byte
  always_ff @(posedge i_serial_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      byte_reg <= '0;
    end else begin
      byte_reg <= byte_next;
    end
  end

  assign o_byte = byte_reg;

endmodule : csp_link_rx

// ==== src/csp_pkg.sv ====
// Types of the channel setup parser: configuration record, link byte, states.
// Assumes csp_regs.svh is on the include path.
`include "csp_regs.svh"

package csp_pkg;

  // Routing code: first letter input side, second output side
  typedef enum logic [1:0] {
    CSP_ROUTE_XX = 2'h0,
    CSP_ROUTE_XY = 2'h1,
    CSP_ROUTE_YX = 2'h2,
    CSP_ROUTE_YY = 2'h3
  } csp_route_e;

  // Parser states, Gray along header, entry, boundary, skip
  typedef enum logic [1:0] {
    CSP_ST_HEADER   = 2'h0,
    CSP_ST_ENTRY    = 2'h1,
    CSP_ST_BOUNDARY = 2'h3,
    CSP_ST_SKIP     = 2'h2
  } csp_state_e;

  // One half-channel setting
  typedef struct packed {
    csp_route_e route;
    logic       conf_alloc;
    logic       codec_alloc_flag;
    logic [3:0] echo_reference_channel;
    logic       decode;
    logic [1:0] rate;
    logic [7:0] echo_delay_ms;
    logic [7:0] in_begin;
    logic [7:0] in_end;
    logic [7:0] out_begin;
    logic [7:0] out_end;
  } csp_hcfg_s;

  // Byte handed across from the serial clock domain
  typedef struct packed {
    logic       toggle;
    logic [7:0] data;
  } csp_link_byte_s;

endpackage : csp_pkg

// ==== src/csp_regs.svh ====
// Constants of the channel setup parser: field positions, reset values and counts.
// Assumes inclusion by bare name from every file that needs them.
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH

// Header byte layout
`define CSP_HDR_ZERO_MSB    7
`define CSP_HDR_ZERO_LSB    2
`define CSP_HDR_ID_MSB      1
`define CSP_HDR_ID_LSB      0
`define CSP_FOOTER          8'hff

// Entry byte 0 layout
`define CSP_B0_ROUTE_MSB    7
`define CSP_B0_ROUTE_LSB    6
`define CSP_B0_CONF_BIT     5
`define CSP_B0_CODEC_BIT    4
`define CSP_B0_REF_MSB      3
`define CSP_B0_REF_LSB      0

// Entry byte 1 layout
`define CSP_B1_ZERO_BIT     7
`define CSP_B1_DEC_BIT      6
`define CSP_B1_PAT_MSB      5
`define CSP_B1_PAT_LSB      2
`define CSP_B1_PATTERN      4'h7
`define CSP_B1_RATE_MSB     1
`define CSP_B1_RATE_LSB     0

// Sequence shape
`define CSP_ENTRY_LAST      3'h6
`define CSP_MAX_ENTRIES     4'h8
`define CSP_BYTE_LAST       3'h7

// Reset values
`define CSP_RST_CONF        1'b0
`define CSP_RST_CODEC       1'b1
`define CSP_RST_RATE        2'h2
`define CSP_RST_DELAY_EC    8'h10
`define CSP_PCM_BITS        8'h08
`define CSP_ADPCM_BITS      8'h04

`endif

// ==== src/csp_sync2.sv ====
// Two flip-flop level synchroniser into the i_clk domain.
// Assumes each bit is a level that is stable for at least two i_clk cycles.
`timescale 1ns/100ps

module csp_sync2 #(
  parameter int          WIDTH = 1,
  parameter logic [31:0] RST   = 32'h0
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_arst_n,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } csp_sync_s;

  csp_sync_s sync_reg;
  csp_sync_s sync_next;

  // First stage feeds only the second stage
  always_comb begin
    sync_next      = sync_reg;
    sync_next.meta = i_async;
    sync_next.sync = sync_reg.meta;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync_reg <= {RST[WIDTH-1:0], RST[WIDTH-1:0]};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg.sync;

endmodule : csp_sync2

// ==== testbench/csp_channel_setup_parser_asserts.sv ====
// Checker for the setup parser: field views, apply pulses and reset values.
// Assumes it is bound to the parser top and sees only its ports.
`timescale 1ns/100ps

module csp_channel_setup_parser_asserts (
  // Clock and reset
  input wire logic                     i_clk,
  input wire logic                     i_arst_n,
  // Observed outputs
  input wire csp_pkg::csp_hcfg_s [7:0] o_cfg,
  input wire logic [7:0]               o_in_on_y,
  input wire logic [7:0]               o_out_on_y,
  input wire logic [7:0]               o_conf_alloc,
  input wire logic [7:0]               o_codec_alloc,
  input wire logic [7:0]               o_echo_alloc,
  input wire logic [7:0]               o_decode,
  input wire logic [7:0][2:0]          o_sample_bits,
  input wire logic                     o_cfg_applied,
  input wire logic                     o_seq_rejected
);
  logic [7:0] h_iny, h_outy, h_conf, h_codec, h_echo, h_dec;
  logic [7:0][2:0] h_bits;

  // Views rebuilt from the record; a swapped or stale flag shows up here
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      h_iny[k]   = o_cfg[k].route[1];
      h_outy[k]  = o_cfg[k].route[0];
      h_conf[k]  = o_cfg[k].conf_alloc;
      h_codec[k] = o_cfg[k].codec_alloc_flag;
      h_echo[k]  = o_cfg[k].echo_delay_ms != 8'h00;
      h_dec[k]   = o_cfg[k].decode;
      h_bits[k]  = {1'b0, o_cfg[k].rate} + 3'h2;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_no_apply;
    (!o_cfg_applied)[*8];
  endsequence

  property p_route;  o_in_on_y == h_iny && o_out_on_y == h_outy; endproperty
  property p_alloc;  o_conf_alloc == h_conf && o_codec_alloc == h_codec; endproperty
  property p_echo;   o_echo_alloc == h_echo; endproperty
  property p_dir;    o_decode == h_dec; endproperty
  property p_rate;   o_sample_bits == h_bits; endproperty
  property p_change; $changed(o_cfg) |-> o_cfg_applied; endproperty
  property p_once;   o_cfg_applied |=> s_no_apply; endproperty
  property p_rej;    o_seq_rejected |=> s_no_apply; endproperty
  property p_dflt;
    $rose(i_arst_n) |-> o_decode == 8'h0f && o_conf_alloc == 8'h00 && o_codec_alloc == 8'hff;
  endproperty

  a_route: assert property (p_route) else $error("route view differs");
  a_alloc: assert property (p_alloc) else $error("alloc view differs");
  a_echo: assert property (p_echo) else $error("echo alloc differs");
  a_dir: assert property (p_dir) else $error("direction differs");
  a_rate: assert property (p_rate) else $error("sample bits differ");
  a_change: assert property (p_change) else $error("settings moved unapplied");
  a_once: assert property (p_once) else $error("apply pulse repeated");
  a_rej: assert property (p_rej) else $error("apply after reject");
  a_dflt: assert property (p_dflt) else $error("reset values wrong");
endmodule : csp_channel_setup_parser_asserts

// ==== testbench/csp_host_model.sv ====
// Host model for the setup port: parks the link, then sends bytes LSB first.
// Assumes the testbench calls its tasks; serial clock runs only inside frames.
`timescale 1ns/100ps

module csp_host_model (
  // Link pins toward the parser
  output logic o_serial_clk,
  output logic o_serial_data_line,
  output logic o_port_select_n
);
  localparam realtime HALF = 62.5;

  // Idle link: clock parked low, select released
  initial begin
    o_serial_clk       = 1'b0;
    o_serial_data_line = 1'b1;
    o_port_select_n    = 1'b1;
  end

  // Select falls a full period before the first rise
  task automatic open_frame();
    o_port_select_n = 1'b0;
    #HALF;
  endtask : open_frame

  // Shift n bits; a short n leaves a partial byte for abort cases
  task automatic send_byte(input logic [7:0] b, input int n = 8);
    for (int i = 0; i < n; i++) begin
      o_serial_data_line = b[i];
      #HALF o_serial_clk = 1'b1;
      #HALF o_serial_clk = 1'b0;
    end
  endtask : send_byte

  // Released line is flipped so a stale bit never looks valid
  task automatic close_frame();
    #HALF o_port_select_n = 1'b1;
    o_serial_data_line = ~o_serial_data_line;
  endtask : close_frame
endmodule : csp_host_model

// ==== testbench/tb.sv ====
// Testbench for the setup parser: reset values, full, empty and faulty frames.
// Assumes the host model drives the link and the checker is bound below.
`timescale 1ns/100ps

module tb;
  logic i_clk = 1'b0;
  logic i_arst_n;
  logic i_identity_strap_high;
  logic i_identity_strap_low;
  logic i_serial_clk, i_serial_data_line, i_port_select_n;
  csp_pkg::csp_hcfg_s [7:0] o_cfg;
  logic [7:0] o_in_on_y, o_out_on_y, o_conf_alloc, o_codec_alloc, o_echo_alloc, o_decode;
  logic [7:0][2:0] o_sample_bits;
  logic o_cfg_applied, o_seq_rejected;
  csp_pkg::csp_hcfg_s exp_cfg [8];
  int fails = 0, tests_run = 0, n_app = 0, n_rej = 0;

  always #5 i_clk = ~i_clk;

  // Pulses stand one cycle, so count them at every edge
  always @(posedge i_clk) begin
    if (o_cfg_applied === 1'b1) n_app <= n_app + 1;
    if (o_seq_rejected === 1'b1) n_rej <= n_rej + 1;
  end

  csp_channel_setup_parser i_dut (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_serial_clk(i_serial_clk),
    .i_serial_data_line(i_serial_data_line), .i_port_select_n(i_port_select_n),
    .i_identity_strap_high(i_identity_strap_high), .i_identity_strap_low(i_identity_strap_low),
    .o_cfg(o_cfg), .o_in_on_y(o_in_on_y), .o_out_on_y(o_out_on_y), .o_conf_alloc(o_conf_alloc),
    .o_codec_alloc(o_codec_alloc), .o_echo_alloc(o_echo_alloc), .o_decode(o_decode),
    .o_sample_bits(o_sample_bits), .o_cfg_applied(o_cfg_applied),
    .o_seq_rejected(o_seq_rejected));

  csp_host_model i_host (.o_serial_clk(i_serial_clk),
    .o_serial_data_line(i_serial_data_line), .o_port_select_n(i_port_select_n));

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  // Power-up settings per half-channel
  function automatic csp_pkg::csp_hcfg_s dflt(input int k);
    csp_pkg::csp_hcfg_s c;
    logic [7:0] j;
    j = 8'(k % 4);
    c = '0;
    c.rate = 2'h2;
    c.codec_alloc_flag = 1'b1;
    c.decode = k < 4;
    c.route = (k < 4) ? csp_pkg::CSP_ROUTE_YY : csp_pkg::CSP_ROUTE_XX;
    c.echo_reference_channel = 4'((k < 4) ? k + 4 : k - 4);
    c.echo_delay_ms = (k < 4) ? 8'h00 : 8'h10;
    c.in_begin = (k < 4) ? j << 2 : j << 3;
    c.in_end = c.in_begin + ((k < 4) ? 8'h03 : 8'h07);
    c.out_begin = (k < 4) ? j << 3 : j << 2;
    c.out_end = c.out_begin + ((k < 4) ? 8'h07 : 8'h03);
    return c;
  endfunction : dflt

  // Entry k: Y-input entries first, input begin rising, entry 0 no delay, then even delays from 10
  function automatic csp_pkg::csp_hcfg_s mk(input int k);
    csp_pkg::csp_hcfg_s e;
    e.route = csp_pkg::csp_route_e'({k < 4, k[0]});
    e.conf_alloc = k[1];
    e.codec_alloc_flag = ~k[0];
    e.echo_reference_channel = 4'(k + 9);
    e.decode = k[0];
    e.rate = 2'(k);
    e.echo_delay_ms = (k == 0) ? 8'h00 : 8'(8 + 2 * k);
    e.in_begin = 8'(16 * k + 1);
    e.in_end = 8'(16 * k + 5);
    e.out_begin = 8'(k + 100);
    e.out_end = 8'(k + 200);
    return e;
  endfunction : mk

  task automatic send_entry(input csp_pkg::csp_hcfg_s e, input logic [3:0] pat);
    i_host.send_byte({e.route, e.conf_alloc, e.codec_alloc_flag, e.echo_reference_channel});
    i_host.send_byte({1'b0, e.decode, pat, e.rate});
    i_host.send_byte(e.echo_delay_ms);
    i_host.send_byte(e.in_begin);
    i_host.send_byte(e.in_end);
    i_host.send_byte(e.out_begin);
    i_host.send_byte(e.out_end);
  endtask : send_entry

  task automatic header(input logic [7:0] h);
    i_host.open_frame();
    i_host.send_byte(h);
  endtask : header

  // Close, wait for a pulse under a bound, then judge counts and all settings
  task automatic finish(input string tn, input int a0, input int r0, input int da, input int dr);
    i_host.close_frame();
    for (int c = 0; c < 40 && n_app + n_rej == a0 + r0; c++) @(posedge i_clk);
    if (da + dr > 0 && n_app + n_rej == a0 + r0) begin
      fails++;
      $display("[ERR] %s pulse expected 1 seen 0", tn);
      results();
    end
    repeat (4) @(posedge i_clk);
    chk("applied", 64'(a0 + da), 64'(n_app));
    chk("rejected", 64'(r0 + dr), 64'(n_rej));
    for (int k = 0; k < 8; k++) begin
      chk($sformatf("cfg%0d", k), 64'(exp_cfg[k]), 64'(o_cfg[k]));
      chk("echo", 64'(exp_cfg[k].echo_delay_ms != 0), 64'(o_echo_alloc[k]));
    end
    $display("test %s done", tn);
  endtask : finish

  logic [7:0] id_hdr;
  int a, r;

  initial begin
    // Reset driven from X so both clock domains see a falling edge at time zero
    i_arst_n              <= 1'b0;
    i_identity_strap_high <= 1'b1;
    i_identity_strap_low  <= 1'b0;
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    id_hdr = {6'h00, i_identity_strap_high, i_identity_strap_low};
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 8; k++) exp_cfg[k] = dflt(k);
    finish("reset", 0, 0, 0, 0);
    // Eight entries cover every route, rate and direction
    a = n_app; r = n_rej;
    header(id_hdr);
    for (int k = 0; k < 8; k++) send_entry(mk(k), 4'h7);
    for (int k = 0; k < 8; k++) exp_cfg[k] = mk(k);
    i_host.send_byte(8'hff);
    finish("full", a, r, 1, 0);
    // New strap level while idle: from here the identity is one
    @(posedge i_clk);
    i_identity_strap_high <= 1'b0;
    i_identity_strap_low  <= 1'b1;
    repeat (4) @(posedge i_clk);
    id_hdr = 8'h01;
    // Empty sequence still applies
    a = n_app; r = n_rej;
    header(id_hdr);
    i_host.send_byte(8'hff);
    finish("empty", a, r, 1, 0);
    // Foreign identity and nonzero upper header bits are ignored silently
    for (int h = 0; h < 2; h++) begin
      a = n_app; r = n_rej;
      header(h == 0 ? id_hdr ^ 8'h01 : id_hdr | 8'h40);
      send_entry(dflt(0), 4'h7);
      i_host.send_byte(8'hff);
      finish("bad header", a, r, 0, 0);
    end
    // Broken fixed pattern in the second entry byte
    a = n_app; r = n_rej;
    header(id_hdr);
    send_entry(dflt(1), 4'h6);
    i_host.send_byte(8'hff);
    finish("bad pattern", a, r, 0, 1);
    // Deselect inside an entry with a partial byte
    a = n_app; r = n_rej;
    header(id_hdr);
    i_host.send_byte(8'h12);
    i_host.send_byte(8'h5d, 3);
    finish("abort", a, r, 0, 1);
    // A ninth entry overflows the table
    a = n_app; r = n_rej;
    header(id_hdr);
    for (int k = 0; k < 8; k++) send_entry(dflt(k), 4'h7);
    i_host.send_byte(8'h00);
    i_host.send_byte(8'hff);
    finish("ninth", a, r, 0, 1);
    results();
  end
endmodule : tb

bind csp_channel_setup_parser csp_channel_setup_parser_asserts i_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .o_cfg(o_cfg), .o_in_on_y(o_in_on_y),
  .o_out_on_y(o_out_on_y), .o_conf_alloc(o_conf_alloc), .o_codec_alloc(o_codec_alloc),
  .o_echo_alloc(o_echo_alloc), .o_decode(o_decode), .o_sample_bits(o_sample_bits),
  .o_cfg_applied(o_cfg_applied), .o_seq_rejected(o_seq_rejected));
